// [src/shutdown_override_pkg.sv]
// Constants for the shutdown override and input source selection block.
// Assumes a single 100 MHz clock domain; no register bus, plain ports only.
package shutdown_override_pkg;

    // Shutdown-state field encodings
    localparam logic [1:0] SD_INACTIVE = 2'h0;
    localparam logic [1:0] SD_TRISTATE = 2'h1;
    localparam logic [1:0] SD_DRIVE_LOW = 2'h2;
    localparam logic [1:0] SD_DRIVE_HIGH = 2'h3;

    // Control byte field positions
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 2;
    localparam int GAP_BIT = 3;
    localparam int SDA_LSB = 4;
    localparam int SDA_MSB = 5;
    localparam int SDB_LSB = 6;
    localparam int SDB_MSB = 7;

    // Reset values
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [1:0] SD_RESET = 2'h0;

    // Input source select codes
    localparam logic [2:0] SRC_NONE0 = 3'h0;
    localparam logic [2:0] SRC_NONE1 = 3'h1;
    localparam logic [2:0] SRC_PWM1 = 3'h2;
    localparam logic [2:0] SRC_PWM2 = 3'h3;
    localparam logic [2:0] SRC_PWM3 = 3'h4;
    localparam logic [2:0] SRC_PWM4 = 3'h5;
    localparam logic [2:0] SRC_PIN = 3'h6;
    localparam logic [2:0] SRC_RESERVED = 3'h7;

    // Output state machine
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SHUT = 2'b01
    } out_state_t;

endpackage

// [src/shutdown_out_stage.sv]
// One output channel: applies the shutdown-state override to a normal level.
// Assumes dead-band timing is done upstream; deadband_done marks its end.
`timescale 1ns/1ps
`default_nettype none
module shutdown_out_stage (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    // Control
    input wire logic shutdown_event_active,
    input wire logic [1:0] shutdown_level,
    input wire logic polarity,
    input wire logic normal_level,
    input wire logic deadband_done,
    // Pin
    output logic pin_out,
    output logic pin_oe
);
    import shutdown_override_pkg::*;

    logic out_d;
    logic out_q;
    logic oe_d;
    logic oe_q;

    // Override decode; polarity only kept for the inactive code
    always_comb begin
        out_d = normal_level ^ polarity;
        oe_d = 1'b1;
        if (shutdown_event_active) begin
            case (shutdown_level)
                SD_DRIVE_HIGH: out_d = 1'b1;
                SD_DRIVE_LOW: out_d = 1'b0;
                SD_TRISTATE: begin
                    out_d = 1'b0;
                    oe_d = 1'b0;
                end
                default: begin
                    // Hold the last level until dead band ends
                    out_d = deadband_done ? polarity : out_q;
                end
            endcase
        end
    end

    // Registered pin drive avoids glitches on the mode change
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;
endmodule // shutdown_out_stage
`default_nettype wire

// [src/shutdown_override_source_sel.sv]
// Shutdown override and input source selection for the complementary
// waveform generator: source mux, control byte image and two pin stages.
// Assumes all inputs synchronous to mclk and dead-band timing done upstream;
// the shutdown flag comes from detection logic outside this block.
//
// Overview of operation
// - Overrides apply only while the shutdown event active bit is set.
// - Output A code 11 drives high, ignoring polarity.
// - Output A code 10 drives low, ignoring polarity.
// - Output A code 01 disables the output driver.
// - Output A code 00 goes inactive after dead band, polarity applied.
// - Output B code 00 goes inactive after dead band, polarity applied.
// - Unimplemented bit 3 of the control byte reads zero.
// - Codes 101,100,011,010 pick PWM channels four, three, two, one.
// - Output B field in bits 7-6 behaves like output A field.
`timescale 1ns/1ps
`default_nettype none
module shutdown_override_source_sel (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Source select code
    input wire logic [2:0] input_source_select,
    // Shutdown-state fields
    input wire logic [1:0] shutdown_level_out_a,
    input wire logic [1:0] shutdown_level_out_b,
    // Output polarity, high inverts
    input wire logic polarity_out_a,
    input wire logic polarity_out_b,
    // Shutdown status
    input wire logic shutdown_event_active,
    // PWM channel outputs
    input wire logic pwm_ch1_output,
    input wire logic pwm_ch2_output,
    input wire logic pwm_ch3_output,
    input wire logic pwm_ch4_output,
    // External generator input pin
    input wire logic generator_input_pin,
    // Normal waveform levels, before polarity
    input wire logic normal_level_a,
    input wire logic normal_level_b,
    // Dead-band elapsed flags
    input wire logic deadband_done_a,
    input wire logic deadband_done_b,
    // Control byte readback
    output logic [7:0] control_readback,
    // Selected generator input
    output logic selected_source,
    // Output A pin
    output logic generator_output_a,
    output logic generator_output_a_oe,
    // Output B pin
    output logic generator_output_b,
    output logic generator_output_b_oe
);
    import shutdown_override_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************

    // Reset release chain
    logic rst_meta_d;
    logic rst_meta_q;
    logic rst_sync_d;
    logic rst_sync_n;

    // Shutdown flag shared by both stages
    logic shutdown_now;

    // Source decode, gating and pick
    logic [4:0] src_hit;
    logic [4:0] src_lvl;
    wire [4:0] src_gated;
    logic src_d;
    logic src_q;

    // Control byte image
    logic [7:0] rb_d;
    logic [7:0] rb_q;

    // ****************************************************************
    // Reset release
    // ****************************************************************

    // Next values of the release chain; the first stage always heads high
    always_comb begin
        rst_meta_d = 1'b1;
        rst_sync_d = rst_meta_q;
    end

    // Two-stage release; only the second stage fans out, so every
    // flop outside the chain leaves reset on the same edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= rst_meta_d;
            rst_sync_n <= rst_sync_d;
        end
    end

    // ****************************************************************
    // Shutdown routing
    // ****************************************************************

    // One fan-out point for the shutdown flag, so both pin stages switch on one edge
    assign shutdown_now = shutdown_event_active;

    // ****************************************************************
    // Input source select
    // ****************************************************************

    // One-hot decode of the source code; undefined and reserved codes
    // hit nothing, so the generator then sees a quiet low input
    always_comb begin
        src_hit = 5'h00;
        case (input_source_select)
            SRC_PWM1: src_hit[0] = 1'b1;
            SRC_PWM2: src_hit[1] = 1'b1;
            SRC_PWM3: src_hit[2] = 1'b1;
            SRC_PWM4: src_hit[3] = 1'b1;
            SRC_PIN: src_hit[4] = 1'b1;
            SRC_NONE0, SRC_NONE1: src_hit = 5'h00;
            default: src_hit = 5'h00;
        endcase
    end

    // Candidate levels in the order of their hit bits
    assign src_lvl = {generator_input_pin, pwm_ch4_output, pwm_ch3_output,
        pwm_ch2_output, pwm_ch1_output};

    // One gate per candidate, so every path has the same depth
    for (genvar i = 0; i < 5; i++) begin : g_src_gate
        assign src_gated[i] = src_lvl[i] & src_hit[i];
    end

    // At most one gate is open, so an OR of all five is the pick
    always_comb begin
        src_d = |src_gated;
    end

    // Registered pick; a change of code shows one edge later, which
    // keeps a decode glitch off the generator input
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            src_q <= 1'b0;
        end else begin
            src_q <= src_d;
        end
    end

    assign selected_source = src_q;

    // ****************************************************************
    // Control byte readback
    // ****************************************************************

    // Control byte image, high bit first:
    //   7..6 output B shutdown-state field
    //   5..4 output A shutdown-state field
    //   3    unused, always low whatever the fields hold
    //   2..0 input source code
    // Software sees the same layout that it writes
    always_comb begin
        rb_d = 8'h00;
        rb_d[SEL_MSB:SEL_LSB] = input_source_select;
        rb_d[GAP_BIT] = 1'b0;
        rb_d[SDA_MSB:SDA_LSB] = shutdown_level_out_a;
        rb_d[SDB_MSB:SDB_LSB] = shutdown_level_out_b;
    end

    // Reset image is built from the reset field values only
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rb_q <= {SD_RESET, SD_RESET, 1'b0, SEL_RESET};
        end else begin
            rb_q <= rb_d;
        end
    end

    assign control_readback = rb_q;

    // ****************************************************************
    // Output A override
    // ****************************************************************

    // Output A channel; code 00 waits on its own dead-band flag, the
    // other codes act on the edge after the shutdown flag rises
    shutdown_out_stage u_out_a (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .shutdown_event_active(shutdown_now),
        .shutdown_level(shutdown_level_out_a),
        .polarity(polarity_out_a),
        .normal_level(normal_level_a),
        .deadband_done(deadband_done_a),
        .pin_out(generator_output_a),
        .pin_oe(generator_output_a_oe)
    );

    // ****************************************************************
    // Output B override
    // ****************************************************************

    // Output B channel, same decode as A with its own polarity and
    // dead-band flag, so the two pins may settle on different edges
    shutdown_out_stage u_out_b (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .shutdown_event_active(shutdown_now),
        .shutdown_level(shutdown_level_out_b),
        .polarity(polarity_out_b),
        .normal_level(normal_level_b),
        .deadband_done(deadband_done_b),
        .pin_out(generator_output_b),
        .pin_oe(generator_output_b_oe)
    );
endmodule // shutdown_override_source_sel
`default_nettype wire

// [sim/shutdown_override_chk.sv]
// Checker for shutdown overrides, source mux and readback layout.
// Assumes one clock; bound to the top module, ports matched by name.
`timescale 1ns/1ps
`default_nettype none
module shutdown_override_chk (
    input wire logic mclk, rst_n, shutdown_event_active, polarity_out_a, polarity_out_b,
    input wire logic pwm_ch1_output, pwm_ch2_output, pwm_ch3_output, pwm_ch4_output,
    input wire logic generator_input_pin, normal_level_a, deadband_done_a, deadband_done_b,
    input wire logic [2:0] input_source_select,
    input wire logic [1:0] shutdown_level_out_a, shutdown_level_out_b,
    input wire logic [7:0] control_readback,
    input wire logic selected_source, generator_output_a, generator_output_a_oe,
    input wire logic generator_output_b, generator_output_b_oe
);
    logic [1:0] cnt_q;
    wire sd = shutdown_event_active;
    wire [1:0] ca = shutdown_level_out_a;
    wire oa = generator_output_a;
    wire ea = generator_output_a_oe;
    // Expected mux pick; undefined codes read as a constant low
    wire [7:0] src_v = {1'b0, generator_input_pin, pwm_ch4_output, pwm_ch3_output,
        pwm_ch2_output, pwm_ch1_output, 2'h0};
    wire src_w = src_v[input_source_select];
    // Outputs only trusted once the reset synchroniser has drained
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 2'h0;
        else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n || cnt_q != 2'h3);
    a_drive_high_a: assert property (sd && ca == 2'h3 |=> oa && ea)
        else $error("out a not high");
    a_drive_low_a: assert property (sd && ca == 2'h2 |=> !oa && ea)
        else $error("out a not low");
    a_tristate_a: assert property (sd && ca == 2'h1 |=> !ea)
        else $error("out a still driven");
    a_idle_a: assert property (
        sd && ca == 2'h0 && deadband_done_a |=> oa == $past(polarity_out_a) && ea)
        else $error("out a not inactive");
    a_idle_b: assert property (
        sd && shutdown_level_out_b == 2'h0 && deadband_done_b
        |=> generator_output_b == $past(polarity_out_b) && generator_output_b_oe)
        else $error("out b not inactive");
    a_tristate_b: assert property (
        sd && shutdown_level_out_b == 2'h1 |=> !generator_output_b_oe)
        else $error("out b still driven");
    a_run_a: assert property (
        !sd |=> oa == ($past(normal_level_a) ^ $past(polarity_out_a)))
        else $error("out a overridden outside shutdown");
    a_source_mux: assert property (
        1'b1 |=> selected_source == $past(src_w))
        else $error("wrong source picked");
    a_gap_zero: assert property (!control_readback[3])
        else $error("gap bit set");
    cover property (sd && ca == 2'h3);
    cover property (input_source_select == 3'h6);
    cover property (sd && shutdown_level_out_b == 2'h0 && deadband_done_b);
    cover property (sd && shutdown_level_out_b == 2'h1);
endmodule // shutdown_override_chk
bind shutdown_override_source_sel shutdown_override_chk u_chk (.*);
`default_nettype wire

// [sim/pwm_src_model.sv]
// Model of the four PWM channel outputs and the external input pin.
// Assumes free-running sources; each bit toggles at its own rate.
`timescale 1ns/1ps
`default_nettype none
module pwm_src_model (
    input wire logic mclk,
    input wire logic rst_n,
    output logic [4:0] src_lvl
);
    logic [4:0] cnt_q;
    // Distinct rates, so a wrong mux pick cannot hide
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 5'h00;
        else cnt_q <= cnt_q + 5'h01;
    end
    assign src_lvl = cnt_q ^ 5'h0a;
endmodule // pwm_src_model
`default_nettype wire

// [sim/shutdown_override_source_sel_tb_top.sv]
// Self-checking bench for shutdown overrides and source selection.
// Assumes the checker is bound in and the source model drives the mux.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
module shutdown_override_source_sel_tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, sea = 1'b0, pa = 1'b0, pb = 1'b0, na = 1'b0, nb = 1'b0;
    logic da = 1'b0, db = 1'b0, ss, oa, ea, ob, eb;
    logic [2:0] sel = 3'h0;
    logic [1:0] sa = 2'h0, sb = 2'h0;
    logic [4:0] lv;
    logic [7:0] rb, v;
    int n_fail = 0, total_checks = 0;
    shutdown_override_source_sel dut (.mclk(mclk), .rst_n(rst_n), .input_source_select(sel),
        .shutdown_level_out_a(sa), .shutdown_level_out_b(sb), .polarity_out_a(pa),
        .polarity_out_b(pb), .shutdown_event_active(sea), .pwm_ch1_output(lv[0]),
        .pwm_ch2_output(lv[1]), .pwm_ch3_output(lv[2]), .pwm_ch4_output(lv[3]),
        .generator_input_pin(lv[4]), .normal_level_a(na), .normal_level_b(nb),
        .deadband_done_a(da), .deadband_done_b(db), .control_readback(rb),
        .selected_source(ss), .generator_output_a(oa), .generator_output_a_oe(ea),
        .generator_output_b(ob), .generator_output_b_oe(eb));
    pwm_src_model src (.mclk(mclk), .rst_n(rst_n), .src_lvl(lv));
    // 100 MHz clock
    initial forever #5 mclk = ~mclk;
    // Drive just after the edge so the design never races the bench
    task automatic step(int n); repeat (n) @(posedge mclk); #1; endtask
    // Shutdown result as {level, enable}
    function automatic logic [1:0] sd_exp(logic [1:0] c, logic p);
        return c == 2'h3 ? 2'b11 : c == 2'h2 ? 2'b01 : c == 2'h1 ? 2'b00 : {p, 1'b1};
    endfunction
    task automatic t_src();
        for (int c = 0; c < 7; c++) begin  // Reserved code never written
            sel = c[2:0];
            step(1);
            repeat (4) begin
                v = {1'b0, lv, 2'h0};
                step(1);
                `CHK(ss, v[sel])
            end
            `CHK(rb[2:0], sel)
        end
    endtask
    task automatic t_shut();
        {sea, da, db} = 3'h7;
        for (int i = 0; i < 8; i++) begin
            {sa, pa} = i[2:0];
            sb = ~sa;
            pb = ~pa;
            step(1);
            `CHK({oa, ea}, sd_exp(sa, pa))
            `CHK({ob, eb}, sd_exp(sb, pb))
            `CHK(rb, {sb, sa, 1'b0, sel})
        end
    endtask
    task automatic t_run();
        {sea, sa, sb} = 5'h0e;
        for (int i = 0; i < 16; i++) begin
            {na, nb, pa, pb} = i[3:0];
            step(1);
            `CHK({oa, ea, ob, eb}, {na ^ pa, 1'b1, nb ^ pb, 1'b1})
        end
    endtask
    task automatic t_hold();
        // Levels chosen so the held and the inactive levels differ on both pins
        {sea, na, nb, pa, pb, da, db} = 7'h38;
        step(1);
        {sea, sa, sb} = 5'h10;
        {na, nb} = 2'h0;
        step(2);
        `CHK({oa, ob}, 2'b01)
        {da, db} = 2'h3;
        step(1);
        `CHK({oa, ob}, {pa, pb})
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence, with a second reset in mid-run
    initial begin
        step(3);
        rst_n = 1'b1;
        step(3);
        t_src();
        t_shut();
        t_run();
        t_hold();
        rst_n = 1'b0;
        step(1);
        rst_n = 1'b1;
        step(3);
        t_shut();
        conclude();
    end
    // Watchdog, well past the 81 cycles needed
    initial begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule // shutdown_override_source_sel_tb_top
`default_nettype wire
